// File: rtl/fct_pkg.sv
// Constants, register map and state codes of the fixed-cycle timer.
package fct_pkg;
    // ****************************************
    // Register map and field positions
    // ****************************************
    localparam logic [7:0] ADDR_PRESET_LOW = 8'h1B;
    localparam logic [7:0] ADDR_PRESET_HIGH = 8'h1C;
    localparam logic [7:0] ADDR_EXTENSION = 8'h1D;
    localparam logic [7:0] ADDR_FLAG = 8'h1E;
    localparam logic [7:0] ADDR_CONTROL = 8'h1F;
    localparam logic [7:0] ADDR_IRQ_CONTROL = 8'h32;
    localparam int EXT_RUN_BIT = 4;
    localparam int FLAG_EVENT_BIT = 4;
    localparam int CTRL_STOP_BIT = 6;
    localparam int CTRL_IRQ_ENABLE_BIT = 4;
    localparam int CTRL_HOLD_BIT = 2;
    localparam int CTRL_BACKUP_ONLY_BIT = 1;
    localparam int CTRL_FILTER_BIT = 0;
    localparam int IRQ_ROUTE_BIT = 2;
    localparam logic [15:0] RESET_PRESET = 16'h0001;
    localparam logic [2:0] RESET_TICK_SELECT = 3'h0;
    // ****************************************
    // Tick sources
    // ****************************************
    localparam logic [2:0] SEL_4096HZ = 3'h0;
    localparam logic [2:0] SEL_64HZ = 3'h1;
    localparam logic [2:0] SEL_1HZ = 3'h2;
    localparam logic [2:0] SEL_MINUTE = 3'h3;
    localparam logic [2:0] SEL_HOUR = 3'h4;
    localparam logic [5:0] DIV_4096_TO_64 = 6'h3F;
    localparam logic [5:0] DIV_64_TO_1 = 6'h3F;
    localparam logic [5:0] DIV_SEC_TO_MIN = 6'h3B;
    localparam logic [5:0] DIV_MIN_TO_HOUR = 6'h3B;
    // ****************************************
    // Timing
    // ****************************************
    localparam int SYS_CLK_HZ = 250000000;
    localparam int SYS_CLK_NS = 4;
    localparam int BASE_TICK_HZ = 4096;
    localparam int BASE_TICK_CYCLES = SYS_CLK_HZ / BASE_TICK_HZ;
    localparam int RELEASE_FAST_NS = 122000;
    localparam int RELEASE_SLOW_NS = 7813000;
    localparam int RELEASE_FAST_CYCLES = (RELEASE_FAST_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
    localparam int RELEASE_SLOW_CYCLES = (RELEASE_SLOW_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
    // ****************************************
    // Interrupt pin states
    // ****************************************
    typedef enum logic [1:0] {
        IRQ_RELEASED = 2'b01,
        IRQ_LOW = 2'b10
    } fct_irq_state_t;
endpackage : fct_pkg

// File: rtl/fct_timer.sv
// Fixed-cycle countdown timer with open-drain interrupt outputs and serial-side register port.
// Functional notes
// RULE1 - Preset must be 1 to 65535.
// RULE2 - Host clears run before writing preset.
// RULE3 - Preset bytes read preset, or live count.
// RULE4 - Host reads count twice until equal.
// RULE5 - Select picks 4096, 64, 1 Hz, minute, hour.
// RULE6 - Interrupt self-releases after 122 us or 7.813 ms.
// RULE7 - First period may be short, bounded.
// RULE8 - Only whole ticks are readable.
// RULE9 - Clearing run keeps a low interrupt.
// RULE10 - Each start reloads the full preset.
// RULE11 - Event flag sticky, cleared by writing zero.
// RULE12 - Enable drives pin low; disabling releases it.
// RULE13 - Filter restricts counting to one supply.
// RULE14 - Hold freezes count, resumes from frozen value.
// RULE15 - Filter enabled makes hold ignored.
// RULE16 - Stop halts all sources except 4096 Hz.
// RULE17 - Route bit picks output a or b.
// RULE18 - Serial write setting run starts counting.
// RULE19 - Two-wire write acknowledge starts counting.
// RULE20 - Count one to zero: event, reload, repeat.
// RULE21 - Preset split into low and high bytes.
module fct_timer #(
    parameter int BASE_TICK_DIV = fct_pkg::BASE_TICK_CYCLES,
    parameter int RELEASE_FAST = fct_pkg::RELEASE_FAST_CYCLES,
    parameter int RELEASE_SLOW = fct_pkg::RELEASE_SLOW_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ser_clk,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wr_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rd_addr,
    output logic [7:0] reg_rdata,
    input wire logic on_backup,
    output logic irq_out_a_n,
    output logic irq_out_a_oe,
    output logic irq_out_b_n,
    output logic irq_out_b_oe
);
    // ****************************************
    // Link side: write capture and read view
    // ****************************************
    logic [7:0] wr_addr_hold, wr_data_hold, next_wr_addr_hold, next_wr_data_hold, next_reg_rdata;
    logic wr_tgl, snap_ack_tgl, next_wr_tgl, next_snap_ack_tgl;
    logic snap_req_s1, snap_req_s2;
    logic [47:0] view, next_view;
    logic snap_tgl;
    logic [47:0] snap_data;

    // The serial clock may stop between frames, so the write path is a bare toggle that needs
    // no answer; bytes arrive at least three serial clocks apart, far slower than the crossing.
    always_comb begin
        next_wr_addr_hold = wr_addr_hold;
        next_wr_data_hold = wr_data_hold;
        next_wr_tgl = wr_tgl;
        next_snap_ack_tgl = snap_ack_tgl;
        next_view = view;
        if (reg_wr) begin // RULE18 RULE19
            next_wr_addr_hold = reg_wr_addr;
            next_wr_data_hold = reg_wdata;
            next_wr_tgl = ~wr_tgl;
        end
        if (snap_req_s2 != snap_ack_tgl) begin
            next_view = snap_data;
            next_snap_ack_tgl = snap_req_s2;
        end
        case (reg_rd_addr)
            fct_pkg::ADDR_PRESET_LOW: next_reg_rdata = next_view[7:0]; // RULE3 RULE21
            fct_pkg::ADDR_PRESET_HIGH: next_reg_rdata = next_view[15:8]; // RULE3 RULE21
            fct_pkg::ADDR_EXTENSION: next_reg_rdata = next_view[23:16];
            fct_pkg::ADDR_FLAG: next_reg_rdata = next_view[31:24];
            fct_pkg::ADDR_CONTROL: next_reg_rdata = next_view[39:32];
            fct_pkg::ADDR_IRQ_CONTROL: next_reg_rdata = next_view[47:40];
            default: next_reg_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge ser_clk or posedge rst) begin
        if (rst) begin
            wr_addr_hold <= 8'h00;
            wr_data_hold <= 8'h00;
            wr_tgl <= 1'b0;
            snap_req_s1 <= 1'b0;
            snap_req_s2 <= 1'b0;
            snap_ack_tgl <= 1'b0;
            view <= 48'h000000000000;
            reg_rdata <= 8'h00;
        end else begin
            wr_addr_hold <= next_wr_addr_hold;
            wr_data_hold <= next_wr_data_hold;
            wr_tgl <= next_wr_tgl;
            snap_req_s1 <= snap_tgl;
            snap_req_s2 <= snap_req_s1;
            snap_ack_tgl <= next_snap_ack_tgl;
            view <= next_view;
            reg_rdata <= next_reg_rdata;
        end
    end

    // ****************************************
    // System side: synchronisers
    // ****************************************
    logic wr_s1, wr_s2, wr_s3, ack_s1, ack_s2, bk_s1, bk_s2;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wr_s1 <= 1'b0;
            wr_s2 <= 1'b0;
            wr_s3 <= 1'b0;
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
            bk_s1 <= 1'b0;
            bk_s2 <= 1'b0;
        end else begin
            wr_s1 <= wr_tgl;
            wr_s2 <= wr_s1;
            wr_s3 <= wr_s2;
            ack_s1 <= snap_ack_tgl;
            ack_s2 <= ack_s1;
            bk_s1 <= on_backup;
            bk_s2 <= bk_s1;
        end
    end
    wire logic wr_now = wr_s2 ^ wr_s3;

    // ****************************************
    // System side: registers, prescaler, counter, interrupt
    // ****************************************
    logic [15:0] preset, count, next_preset, next_count;
    logic [2:0] tick_sel, next_tick_sel;
    logic run, run_prev, evt_flag, irq_ie, stop, hold, bkon, bke, route;
    logic next_run, next_evt_flag, next_irq_ie, next_stop, next_hold, next_bkon, next_bke;
    logic next_route;
    logic [15:0] base_cnt, next_base_cnt;
    logic [5:0] c64, c1, cmin, chour, next_c64, next_c1, next_cmin, next_chour;
    fct_pkg::fct_irq_state_t irq_state, next_irq_state;
    logic [20:0] rel_cnt, next_rel_cnt;
    logic next_snap_tgl;
    logic [47:0] next_snap_data;
    logic t4096, t64, t1, tmin, thour, tick, start, count_en, supply_ok, hold_eff, event_now;

    always_comb begin
        next_preset = preset;
        next_tick_sel = tick_sel;
        next_run = run;
        next_irq_ie = irq_ie;
        next_stop = stop;
        next_hold = hold;
        next_bkon = bkon;
        next_bke = bke;
        next_route = route;
        next_evt_flag = evt_flag;
        if (wr_now) begin
            case (wr_addr_hold)
                fct_pkg::ADDR_PRESET_LOW: next_preset[7:0] = wr_data_hold; // RULE21
                fct_pkg::ADDR_PRESET_HIGH: next_preset[15:8] = wr_data_hold; // RULE21
                fct_pkg::ADDR_EXTENSION: begin
                    next_run = wr_data_hold[fct_pkg::EXT_RUN_BIT];
                    next_tick_sel = wr_data_hold[2:0];
                end
                fct_pkg::ADDR_FLAG: begin
                    if (!wr_data_hold[fct_pkg::FLAG_EVENT_BIT]) begin // RULE11
                        next_evt_flag = 1'b0;
                    end
                end
                fct_pkg::ADDR_CONTROL: begin
                    next_stop = wr_data_hold[fct_pkg::CTRL_STOP_BIT];
                    next_irq_ie = wr_data_hold[fct_pkg::CTRL_IRQ_ENABLE_BIT];
                    next_hold = wr_data_hold[fct_pkg::CTRL_HOLD_BIT];
                    next_bkon = wr_data_hold[fct_pkg::CTRL_BACKUP_ONLY_BIT];
                    next_bke = wr_data_hold[fct_pkg::CTRL_FILTER_BIT];
                end
                fct_pkg::ADDR_IRQ_CONTROL: next_route = wr_data_hold[fct_pkg::IRQ_ROUTE_BIT];
                default: next_route = route;
            endcase
        end

        // Free-running chain; only whole ticks of the chosen source reach the counter.
        t4096 = (base_cnt == 16'(BASE_TICK_DIV - 1));
        next_base_cnt = t4096 ? 16'h0000 : base_cnt + 16'h0001;
        t64 = t4096 && (c64 == fct_pkg::DIV_4096_TO_64);
        t1 = t64 && (c1 == fct_pkg::DIV_64_TO_1);
        tmin = t1 && (cmin == fct_pkg::DIV_SEC_TO_MIN);
        thour = tmin && (chour == fct_pkg::DIV_MIN_TO_HOUR);
        next_c64 = t4096 ? c64 + 6'h01 : c64;
        next_c1 = t64 ? c1 + 6'h01 : c1;
        next_cmin = tmin ? 6'h00 : (t1 ? cmin + 6'h01 : cmin);
        next_chour = thour ? 6'h00 : (tmin ? chour + 6'h01 : chour);
        case (tick_sel) // RULE5
            fct_pkg::SEL_4096HZ: tick = t4096;
            fct_pkg::SEL_64HZ: tick = t64;
            fct_pkg::SEL_1HZ: tick = t1;
            fct_pkg::SEL_MINUTE: tick = tmin;
            fct_pkg::SEL_HOUR: tick = thour;
            default: tick = 1'b0;
        endcase

        start = run && !run_prev;
        supply_ok = !bke || (bkon == bk_s2); // RULE13
        hold_eff = hold && !bke; // RULE14 RULE15
        count_en = run && !start && supply_ok && !hold_eff
            && !(stop && tick_sel != fct_pkg::SEL_4096HZ); // RULE16
        event_now = count_en && tick && (count == 16'h0001); // RULE20
        next_count = count;
        if (start) begin
            next_count = preset; // RULE10
            // Restarting the minute and hour stages keeps the short first period within one
            // second for those sources; faster sources are short by under one tick.
            next_cmin = 6'h00; // RULE7
            next_chour = 6'h00; // RULE7
        end else if (event_now) begin
            next_count = preset; // RULE20
        end else if (count_en && tick) begin
            next_count = count - 16'h0001; // RULE8
        end
        if (event_now) begin
            next_evt_flag = 1'b1; // RULE11
        end

        next_irq_state = irq_state;
        next_rel_cnt = rel_cnt;
        if (event_now && irq_ie) begin // RULE12
            next_irq_state = fct_pkg::IRQ_LOW;
            next_rel_cnt = (tick_sel == fct_pkg::SEL_4096HZ) ? 21'(RELEASE_FAST - 1)
                : 21'(RELEASE_SLOW - 1); // RULE6
        end else if (irq_state == fct_pkg::IRQ_LOW) begin
            // Run is not looked at here: stopping the timer leaves the pin low.
            if (!irq_ie || rel_cnt == 21'h000000) begin // RULE12 RULE6 RULE9
                next_irq_state = fct_pkg::IRQ_RELEASED;
            end else begin
                next_rel_cnt = rel_cnt - 21'h000001;
            end
        end

        // Read view: live count while running, preset otherwise; stable until acknowledged.
        next_snap_tgl = snap_tgl;
        next_snap_data = snap_data;
        if (ack_s2 == snap_tgl) begin
            next_snap_tgl = ~snap_tgl;
            next_snap_data = {5'h00, route, 2'h0, 1'b0, next_stop, 1'b0, next_irq_ie, 1'b0,
                next_hold, next_bkon, next_bke, 3'h0, next_evt_flag, 4'h0,
                3'h0, next_run, 1'b0, next_tick_sel,
                next_run ? next_count : next_preset}; // RULE3
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            preset <= fct_pkg::RESET_PRESET; // RULE1
            count <= fct_pkg::RESET_PRESET;
            tick_sel <= fct_pkg::RESET_TICK_SELECT;
            run <= 1'b0;
            run_prev <= 1'b0;
            evt_flag <= 1'b0;
            irq_ie <= 1'b0;
            stop <= 1'b0;
            hold <= 1'b0;
            bkon <= 1'b0;
            bke <= 1'b0;
            route <= 1'b0;
            base_cnt <= 16'h0000;
            c64 <= 6'h00;
            c1 <= 6'h00;
            cmin <= 6'h00;
            chour <= 6'h00;
            irq_state <= fct_pkg::IRQ_RELEASED;
            rel_cnt <= 21'h000000;
            snap_tgl <= 1'b0;
            snap_data <= 48'h000000000000;
        end else begin
            preset <= next_preset;
            count <= next_count;
            tick_sel <= next_tick_sel;
            run <= next_run;
            run_prev <= run;
            evt_flag <= next_evt_flag;
            irq_ie <= next_irq_ie;
            stop <= next_stop;
            hold <= next_hold;
            bkon <= next_bkon;
            bke <= next_bke;
            route <= next_route;
            base_cnt <= next_base_cnt;
            c64 <= next_c64;
            c1 <= next_c1;
            cmin <= next_cmin;
            chour <= next_chour;
            irq_state <= next_irq_state;
            rel_cnt <= next_rel_cnt;
            snap_tgl <= next_snap_tgl;
            snap_data <= next_snap_data;
        end
    end

    // Open-drain pins: the data level is always low, only the enable moves.
    assign irq_out_a_n = 1'b0;
    assign irq_out_b_n = 1'b0;
    assign irq_out_a_oe = (irq_state == fct_pkg::IRQ_LOW) && route; // RULE17
    assign irq_out_b_oe = (irq_state == fct_pkg::IRQ_LOW) && !route; // RULE17

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    AST_START_LOADS_PRESET: assert property ($rose(run) |=> count == $past(preset)) // RULE10
        else $error("start did not load the preset");
    AST_EVENT_RELOAD_FLAG: assert property (event_now // RULE20
        |=> evt_flag && count == $past(preset))
        else $error("event did not set flag and reload");
    AST_FLAG_STICKY: assert property (evt_flag && !wr_now |=> evt_flag) // RULE11
        else $error("event flag dropped without a clear");
    AST_IE_OFF_RELEASES: assert property ((irq_state == fct_pkg::IRQ_LOW) && !irq_ie // RULE12
        |=> irq_state == fct_pkg::IRQ_RELEASED)
        else $error("disabling interrupts did not release the pin");
    AST_ROUTE: assert property (irq_out_a_oe |-> route && !irq_out_b_oe) // RULE17
        else $error("interrupt on wrong output");
    AST_HOLD_FREEZE: assert property (run && run_prev && hold && !bke // RULE14
        |=> $stable(count))
        else $error("count moved while held");
    AST_STOP_HALTS: assert property (stop && tick_sel != fct_pkg::SEL_4096HZ // RULE16
        |-> !count_en)
        else $error("count ran while stopped");
    AST_FILTER: assert property (bke && (bkon != bk_s2) |-> !count_en) // RULE13
        else $error("count ran on filtered supply");
    AST_RUN_OFF_KEEPS_IRQ: assert property ((irq_state == fct_pkg::IRQ_LOW) && irq_ie // RULE9
        && rel_cnt != 21'h000000 |=> irq_state == fct_pkg::IRQ_LOW)
        else $error("pin released early");
    AST_FAST_RELEASE: assert property (event_now && irq_ie // RULE6
        && tick_sel == fct_pkg::SEL_4096HZ |=> rel_cnt == 21'(RELEASE_FAST - 1))
        else $error("wrong release time loaded");
endmodule : fct_timer

// File: verif/fct_host_model.sv
// Host processor model that drives the serial register port of the timer.
module fct_host_model (
    output logic ser_clk,
    output logic reg_wr,
    output logic [7:0] reg_wr_addr,
    output logic [7:0] reg_wdata,
    output logic [7:0] reg_rd_addr,
    input wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        ser_clk = 1'b0;
        reg_wr = 1'b0;
        reg_wr_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_rd_addr = 8'h00;
    end

    // The link clock runs only inside a frame and rests low between frames.
    task automatic pulse(input int n);
        repeat (n) begin
            #32 ser_clk = 1'b1;
            #32 ser_clk = 1'b0;
        end
    endtask : pulse

    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        // A lead-in of no whole number of system periods keeps link edges off system edges.
        #5.3;
        reg_wr_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        pulse(1);
        reg_wr = 1'b0;
        // Released data shows the inverse, so a stale byte cannot pass for a fresh one.
        reg_wdata = ~d;
        pulse(2);
    endtask : write_reg

    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        #5.3;
        reg_rd_addr = a;
        pulse(6);
        d = reg_rdata;
    endtask : read_reg

    // The live count is not frozen during an access, so a value is kept once two reads agree.
    task automatic read_stable(input logic [7:0] a, output logic [7:0] d);
        logic [7:0] prev;
        read_reg(a, prev);
        read_reg(a, d);
        for (int i = 0; i < 4 && d !== prev; i++) begin
            prev = d;
            read_reg(a, d);
        end
    endtask : read_stable

    task automatic write_preset(input logic [15:0] p);
        if (p != 16'h0000) begin
            write_reg(fct_pkg::ADDR_EXTENSION, 8'h00);
            write_reg(fct_pkg::ADDR_PRESET_LOW, p[7:0]);
            write_reg(fct_pkg::ADDR_PRESET_HIGH, p[15:8]);
        end
    endtask : write_preset
endmodule : fct_host_model

// File: verif/fct_timer_tb_top.sv
// Self-checking testbench of the fixed-cycle timer.
module fct_timer_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int REL_FAST = 8;
    localparam int REL_SLOW = 400;
    logic sys_clk, rst, on_backup, ser_clk, reg_wr;
    logic [7:0] reg_wr_addr, reg_wdata, reg_rd_addr, reg_rdata, rd;
    logic irq_out_a_n, irq_out_a_oe, irq_out_b_n, irq_out_b_oe;
    // Both interrupt lines are open drain with a pull-up.
    wire irq_a = irq_out_a_oe ? irq_out_a_n : 1'b1;
    wire irq_b = irq_out_b_oe ? irq_out_b_n : 1'b1;
    int n_errors = 0;
    int n_tests = 0;
    int cycles = 0;

    fct_timer #(.BASE_TICK_DIV(4), .RELEASE_FAST(REL_FAST), .RELEASE_SLOW(REL_SLOW)) fct_timer_inst (
        .sys_clk(sys_clk), .rst(rst), .ser_clk(ser_clk), .reg_wr(reg_wr),
        .reg_wr_addr(reg_wr_addr), .reg_wdata(reg_wdata), .reg_rd_addr(reg_rd_addr),
        .reg_rdata(reg_rdata), .on_backup(on_backup), .irq_out_a_n(irq_out_a_n),
        .irq_out_a_oe(irq_out_a_oe), .irq_out_b_n(irq_out_b_n), .irq_out_b_oe(irq_out_b_oe));
    fct_host_model fct_host_model_inst (
        .ser_clk(ser_clk), .reg_wr(reg_wr), .reg_wr_addr(reg_wr_addr), .reg_wdata(reg_wdata),
        .reg_rd_addr(reg_rd_addr), .reg_rdata(reg_rdata));

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // ****************************************
    // Checking and closing
    // ****************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test();
        $display("mismatches %0d, comparisons %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test

    // The whole run needs about 8000 cycles; the ceiling leaves ample margin.
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            finish_test();
        end
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        fct_host_model_inst.write_reg(a, d);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        fct_host_model_inst.read_reg(a, rd);
        check(16'(rd), 16'(exp));
    endtask : rdc

    task automatic wait_low(input bit on_a, input int lim);
        int n;
        n = 0;
        while ((on_a ? irq_a : irq_b) !== 1'b0 && n < lim) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        check(16'(n < lim), 16'h0001);
    endtask : wait_low

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        logic [7:0] addrs [7] = '{fct_pkg::ADDR_PRESET_LOW, fct_pkg::ADDR_PRESET_HIGH,
            fct_pkg::ADDR_EXTENSION, fct_pkg::ADDR_FLAG, fct_pkg::ADDR_CONTROL,
            fct_pkg::ADDR_IRQ_CONTROL, 8'h20};
        for (int i = 0; i < 7; i++) begin
            rdc(addrs[i], i == 0 ? 8'h01 : 8'h00);
        end
    endtask : t_reset

    task automatic t_event();
        int hi, lo;
        fct_host_model_inst.write_preset(16'h0003);
        rdc(fct_pkg::ADDR_PRESET_LOW, 8'h03);
        rdc(fct_pkg::ADDR_PRESET_HIGH, 8'h00);
        wr(fct_pkg::ADDR_IRQ_CONTROL, 8'h04);
        wr(fct_pkg::ADDR_CONTROL, 8'h10);
        wr(fct_pkg::ADDR_EXTENSION, 8'h10);
        wait_low(1'b1, 200);
        check(16'(irq_out_b_oe), 16'h0000);
        hi = 0;
        lo = 0;
        // The first low phase found may be half over, so measure from the next falling edge.
        while (irq_a === 1'b0 && lo < 100) begin
            @(posedge sys_clk);
            #1;
            lo++;
        end
        wait_low(1'b1, 100);
        lo = 0;
        while (irq_a === 1'b0 && hi < 100) begin
            @(posedge sys_clk);
            #1;
            hi++;
        end
        check(16'(hi), 16'(REL_FAST));
        while (irq_a === 1'b1 && lo < 100) begin
            @(posedge sys_clk);
            #1;
            lo++;
        end
        check(16'(hi + lo), 16'h000C);
        wr(fct_pkg::ADDR_EXTENSION, 8'h00);
        rdc(fct_pkg::ADDR_PRESET_LOW, 8'h03);
        rdc(fct_pkg::ADDR_FLAG, 8'h10);
        wr(fct_pkg::ADDR_FLAG, 8'hFF);
        rdc(fct_pkg::ADDR_FLAG, 8'h10);
        wr(fct_pkg::ADDR_FLAG, 8'h00);
        rdc(fct_pkg::ADDR_FLAG, 8'h00);
    endtask : t_event

    task automatic t_slow();
        wr(fct_pkg::ADDR_IRQ_CONTROL, 8'h00);
        fct_host_model_inst.write_preset(16'h0002);
        wr(fct_pkg::ADDR_EXTENSION, 8'h11);
        wait_low(1'b0, 1500);
        check(16'(irq_out_a_oe), 16'h0000);
        wr(fct_pkg::ADDR_EXTENSION, 8'h01);
        check(16'(irq_b), 16'h0000);
        wr(fct_pkg::ADDR_CONTROL, 8'h00);
        repeat (8) @(posedge sys_clk);
        #1;
        check(16'(irq_b), 16'h0001);
    endtask : t_slow

    // Each entry is frozen, on_backup and the control byte.
    task automatic t_hold();
        logic [9:0] cases [7] = '{10'h204, 10'h005, 10'h040, 10'h301, 10'h103, 10'h203, 10'h100};
        logic [7:0] a, b;
        fct_host_model_inst.write_preset(16'hFFFF);
        wr(fct_pkg::ADDR_EXTENSION, 8'h10);
        foreach (cases[i]) begin
            @(posedge sys_clk) on_backup <= cases[i][8];
            wr(fct_pkg::ADDR_CONTROL, cases[i][7:0]);
            repeat (20) @(posedge sys_clk);
            fct_host_model_inst.read_reg(fct_pkg::ADDR_PRESET_LOW, a);
            repeat (200) @(posedge sys_clk);
            fct_host_model_inst.read_reg(fct_pkg::ADDR_PRESET_LOW, b);
            check(16'(a === b), 16'(cases[i][9]));
        end
        @(posedge sys_clk) on_backup <= 1'b0;
        wr(fct_pkg::ADDR_CONTROL, 8'h00);
    endtask : t_hold

    task automatic t_restart();
        logic [7:0] a, b;
        fct_host_model_inst.write_preset(16'h1234);
        wr(fct_pkg::ADDR_EXTENSION, 8'h11);
        repeat (600) @(posedge sys_clk);
        wr(fct_pkg::ADDR_EXTENSION, 8'h01);
        wr(fct_pkg::ADDR_EXTENSION, 8'h11);
        fct_host_model_inst.read_stable(fct_pkg::ADDR_PRESET_LOW, rd);
        check(16'(rd == 8'h34 || rd == 8'h33), 16'h0001);
        // The global stop must freeze the slower sources; 600 cycles hold at least two ticks.
        wr(fct_pkg::ADDR_CONTROL, 8'h40);
        fct_host_model_inst.read_reg(fct_pkg::ADDR_PRESET_LOW, a);
        repeat (600) @(posedge sys_clk);
        fct_host_model_inst.read_reg(fct_pkg::ADDR_PRESET_LOW, b);
        check(16'(b), 16'(a));
        wr(fct_pkg::ADDR_CONTROL, 8'h00);
    endtask : t_restart

    initial begin
        rst = 1'b1;
        on_backup = 1'b0;
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (20) @(posedge sys_clk);
        t_reset();
        t_event();
        t_slow();
        t_hold();
        t_restart();
        finish_test();
    end
endmodule : fct_timer_tb_top
